// *** pkg/digitizer_params.svh ***
`ifndef DIGITIZER_PARAMS_SVH
`define DIGITIZER_PARAMS_SVH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_PERIOD_NS 25
`define ACTIVITY_WINDOW_MS 30
`define VSEP_PULSE_NS 8000
`define VSEP_CYCLES ((`VSEP_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_PLL_DIV_HIGH 8'h01
`define REG_PLL_DIV_LOW 8'h02
`define REG_PLL_VCO_PUMP 8'h03
`define REG_PLL_OUT_DIV 8'h04
`define REG_SYNC_SELECT 8'h0E
`define REG_SLICE 8'h10
`define REG_STATUS 8'h14
`define REG_OUT_FORMAT 8'h15
`define REG_CSC_CTRL 8'h18
`define REG_GLITCH 8'h1A
`define REG_CLOCK_SRC 8'h1F
`define REG_COEF_BASE 8'h4A
`define COEF_BYTES 18
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define DIV_LOW_LSB 4
`define VCO_LSB 6
`define PUMP_LSB 3
`define SLICE_LSB 3
`define FORMAT_422_BIT 1
`define CSC_BYPASS_BIT 4
`define HSYNC_AUTO_OUTPUT_SELECT_BIT 7
`define HMAN_SOG_BIT 6
`define VSYNC_AUTO_OUTPUT_SELECT_BIT 4
`define VMAN_SEP_BIT 3
`define EXT_CLK_BIT 0
`define SLICE_RESET 8'h58
`define SYNC_SELECT_RESET 8'h90
`define CSC_CTRL_RESET 8'h10
`define COEF_RESET {16'h16E3, 16'h024F, 16'h06CE, 16'hF3AB, 16'h1000, 16'hFC55, \
  16'hF178, 16'hFE88, 16'h1000}
`define COEF_FRAC 12
`define CHROMA_OFFSET 10'h200
// ----------------------------------------
// Half-band filter
// ----------------------------------------
`define HB_CENTER_COEF 16'h0200
`define HB_PAIR_COEFS {16'h0006, 16'hFFF4, 16'h0015, 16'hFFDE, 16'h0037, 16'hFF9B, 16'h0141}
`define HB_SHIFT 10
`endif

// *** pkg/digitizer_pkg.sv ***
package digitizer_pkg;
  typedef logic [9:0] sample_t;
  typedef enum logic [8:0] {
    I2C_IDLE = 9'h001,
    I2C_ADDR = 9'h002,
    I2C_ADDR_ACK = 9'h004,
    I2C_SUB = 9'h008,
    I2C_SUB_ACK = 9'h010,
    I2C_WR = 9'h020,
    I2C_WR_ACK = 9'h040,
    I2C_RD = 9'h080,
    I2C_RD_ACK = 9'h100
  } i2c_state_t;
endpackage

// *** rtl/two_entry_buffer.sv ***
`timescale 1ns/100ps
module two_entry_buffer #(
  parameter int WIDTH = 30
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  typedef struct packed {
    logic [WIDTH-1:0] e0;
    logic [WIDTH-1:0] e1;
    logic v0;
    logic v1;
    logic ready;
  } buf_state_t;

  buf_state_t s_q;
  buf_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.v0 && out_ready) begin
      s_d.e0 = s_q.e1;
      s_d.v0 = s_q.v1;
      s_d.v1 = 1'b0;
    end
    if (in_valid && s_q.ready) begin
      if (s_d.v0) begin
        s_d.e1 = in_data;
        s_d.v1 = 1'b1;
      end else begin
        s_d.e0 = in_data;
        s_d.v0 = 1'b1;
      end
    end
    s_d.ready = !s_d.v1;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready = s_q.ready;
  assign out_data = s_q.e0;
  assign out_valid = s_q.v0;
endmodule // two_entry_buffer

// *** rtl/video_digitizer_back_end.sv ***
// Operation
// [R1] Sample clock may come from external pin
// [R2] Feedback divider split over registers 01h/02h
// [R3] VCO range field in 03h bits 7:6
// [R4] Charge pump field in 03h bits 5:3
// [R5] Output divider in 04h bit 0
// [R6] Converter bypass bit, bypassed after reset
// [R7] Programmable coefficients reset to HD matrix
// [R8] 27-tap half-band chroma decimation by two
// [R9] 15h bit 1 selects 4:4:4 or 4:2:2
// [R10] 4:2:2 puts alternating Cb/Cr on blue
// [R11] Decimation follows colour conversion
// [R12] Sync source picked by input activity
// [R13] Sliced sync on its own output pin
// [R14] Slice threshold code in 10h, reset 11
// [R15] Glitch filter, three cutoffs, bypassed at reset
// [R16] Separator splits composite into H and V
// [R17] Activity detected per sync input
// [R18] Host treats vsync activity as 5-wire
// [R19] Auto mode with both active uses pins
// [R20] Only hsync active: decode vsync from it
// [R21] No discrete activity: use green sync input
// [R22] Activity readable in status register 14h
// [R23] Activity held while edges within timeout
// [R24] Signed coefficients, rounded, clipped sum
`timescale 1ns/100ps
`include "digitizer_params.svh"
module video_digitizer_back_end #(
  parameter logic [6:0] DEVICE_ADDR = 7'h5C,
  parameter int ACT_TIMEOUT = `ACTIVITY_WINDOW_MS * 1000000 / `CLK_PERIOD_NS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] hsync_in,
  input wire logic vsync_in,
  input wire logic [2:0] green_embedded_sync_input,
  input wire digitizer_pkg::sample_t pix_green,
  input wire digitizer_pkg::sample_t pix_blue,
  input wire digitizer_pkg::sample_t pix_red,
  input wire logic pix_valid,
  output logic pix_ready,
  output digitizer_pkg::sample_t green_output_bus,
  output digitizer_pkg::sample_t blue_output_bus,
  output digitizer_pkg::sample_t red_output_bus,
  output logic out_valid,
  input wire logic out_ready,
  output logic [11:0] pll_feedback_divide,
  output logic [1:0] vco_range,
  output logic [2:0] charge_pump_setting,
  output logic pll_output_divide,
  output logic sample_clock_external,
  output logic [4:0] slice_threshold_code,
  output logic [1:0] glitch_filter_cutoff,
  output logic sliced_sync_output,
  output logic pll_ref_sync,
  output logic hsync_out,
  output logic vsync_out
);
  import digitizer_pkg::*;

  localparam int CW = $clog2(ACT_TIMEOUT + 1);

  typedef struct packed {
    i2c_state_t st;
    logic [7:0] sh;
    logic [3:0] bit_cnt;
    logic [7:0] sub;
    logic rd;
    logic scl_q;
    logic sda_q;
    logic sda_oe;
    logic sda_out;
    logic [7:0] div_hi;
    logic [7:0] div_lo;
    logic [7:0] vco_pump;
    logic [7:0] out_div;
    logic [7:0] sync_sel;
    logic [7:0] slice;
    logic [7:0] fmt;
    logic [7:0] csc_ctrl;
    logic [7:0] glitch;
    logic [7:0] clk_src;
    logic [0:`COEF_BYTES-1][7:0] coef;
    logic [5:0] act_prev;
    logic [5:0][CW-1:0] act_cnt;
    logic [5:0] act;
    logic [2:0] gf_cnt;
    logic gf_level;
    logic cs_prev;
    logic [8:0] width;
    logic long_p;
    logic vsep;
    logic ref_sync;
    logic vs_out;
    logic [13:0][9:0] y_line;
    logic [26:0][9:0] cb_line;
    logic [26:0][9:0] cr_line;
    logic phase;
    logic [9:0] cr_hold;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ----------------------------------------
  // Arithmetic helpers
  // ----------------------------------------
  function automatic logic [9:0] clip10(input logic signed [28:0] t);
    if (t < 0) clip10 = 10'h000;
    else if (t > 29'sd1023) clip10 = 10'h3FF;
    else clip10 = t[9:0];
  endfunction

  function automatic logic [9:0] csc_mac(input logic [15:0] cg, input logic [15:0] cb,
      input logic [15:0] cr, input sample_t g, input sample_t b, input sample_t r,
      input logic [9:0] off);
    logic signed [28:0] acc;
    acc = $signed(cg) * $signed({1'b0, g}) + $signed(cb) * $signed({1'b0, b})
        + $signed(cr) * $signed({1'b0, r}); // R24
    acc = (acc + 29'sh800) >>> `COEF_FRAC;
    acc = acc + $signed({19'h0, off});
    csc_mac = clip10(acc); // R24
  endfunction

  function automatic logic [9:0] halfband(input logic [26:0][9:0] x);
    logic signed [28:0] acc;
    logic [6:0][15:0] h;
    h = `HB_PAIR_COEFS;
    acc = $signed(`HB_CENTER_COEF) * $signed({1'b0, x[13]});
    for (int k = 0; k < 7; k++) begin
      acc = acc + $signed(h[k]) * ($signed({2'b0, x[12-2*k]}) + $signed({2'b0, x[14+2*k]}));
    end
    acc = (acc + 29'sh200) >>> `HB_SHIFT;
    halfband = clip10(acc); // R8
  endfunction

  function automatic logic [15:0] coef_word(input state_t s, input int k);
    coef_word = {s.coef[2*k], s.coef[2*k+1]};
  endfunction

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  function automatic logic [7:0] reg_read(input state_t s, input logic [7:0] a);
    case (a)
      `REG_PLL_DIV_HIGH: reg_read = s.div_hi;
      `REG_PLL_DIV_LOW: reg_read = s.div_lo;
      `REG_PLL_VCO_PUMP: reg_read = s.vco_pump;
      `REG_PLL_OUT_DIV: reg_read = s.out_div;
      `REG_SYNC_SELECT: reg_read = s.sync_sel;
      `REG_SLICE: reg_read = s.slice;
      `REG_STATUS: reg_read = {5'h00, |s.act[5:3], s.act[2], |s.act[1:0]}; // R22
      `REG_OUT_FORMAT: reg_read = s.fmt;
      `REG_CSC_CTRL: reg_read = s.csc_ctrl;
      `REG_GLITCH: reg_read = s.glitch;
      `REG_CLOCK_SRC: reg_read = s.clk_src;
      default: begin
        if (a >= `REG_COEF_BASE && a < `REG_COEF_BASE + 8'(`COEF_BYTES)) begin
          reg_read = s.coef[5'(a - `REG_COEF_BASE)];
        end else begin
          reg_read = 8'h00;
        end
      end
    endcase
  endfunction

  function automatic state_t reg_write(input state_t s, input logic [7:0] a, input logic [7:0] v);
    reg_write = s;
    case (a)
      `REG_PLL_DIV_HIGH: reg_write.div_hi = v; // R2
      `REG_PLL_DIV_LOW: reg_write.div_lo = v; // R2
      `REG_PLL_VCO_PUMP: reg_write.vco_pump = v; // R3
      `REG_PLL_OUT_DIV: reg_write.out_div = v; // R5
      `REG_SYNC_SELECT: reg_write.sync_sel = v;
      `REG_SLICE: reg_write.slice = v; // R14
      `REG_OUT_FORMAT: reg_write.fmt = v; // R9
      `REG_CSC_CTRL: reg_write.csc_ctrl = v; // R6
      `REG_GLITCH: reg_write.glitch = v; // R15
      `REG_CLOCK_SRC: reg_write.clk_src = v; // R1
      default: begin
        if (a >= `REG_COEF_BASE && a < `REG_COEF_BASE + 8'(`COEF_BYTES)) begin
          reg_write.coef[5'(a - `REG_COEF_BASE)] = v; // R7
        end
      end
    endcase
  endfunction

  // ----------------------------------------
  // Data path wiring
  // ----------------------------------------
  logic buf_ready;
  logic push;
  logic [5:0] act_in;
  logic hs_act;
  logic hs_pin;
  logic sog_raw;
  logic ref_d;
  logic [9:0] yc;
  logic [9:0] cbc;
  logic [9:0] crc;
  logic [9:0] blue_d;
  logic [9:0] red_d;
  logic [2:0] gf_limit;

  assign push = pix_valid && buf_ready;
  assign act_in = {green_embedded_sync_input, vsync_in, hsync_in};

  always_comb begin
    s_d = s_q;
    s_d.sda_out = 1'b0;
    s_d.scl_q = scl_in;
    s_d.sda_q = sda_in;
    // I2C slave: sample on rising SCL, drive on falling SCL
    if (s_q.scl_q && scl_in && s_q.sda_q && !sda_in) begin
      s_d.st = I2C_ADDR;
      s_d.bit_cnt = 4'h0;
      s_d.sda_oe = 1'b0;
    end else if (s_q.scl_q && scl_in && !s_q.sda_q && sda_in) begin
      s_d.st = I2C_IDLE;
      s_d.sda_oe = 1'b0;
    end else if (!s_q.scl_q && scl_in) begin
      if (s_q.st == I2C_ADDR || s_q.st == I2C_SUB || s_q.st == I2C_WR) begin
        s_d.sh = {s_q.sh[6:0], sda_in};
        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
      end else if (s_q.st == I2C_RD_ACK && sda_in) begin
        s_d.st = I2C_IDLE;
      end
    end else if (s_q.scl_q && !scl_in) begin
      case (s_q.st)
        I2C_ADDR: begin
          if (s_q.bit_cnt == 4'h8) begin
            if (s_q.sh[7:1] == DEVICE_ADDR) begin
              s_d.st = I2C_ADDR_ACK;
              s_d.rd = s_q.sh[0];
              s_d.sda_oe = 1'b1;
            end else begin
              s_d.st = I2C_IDLE;
            end
          end
        end
        I2C_ADDR_ACK, I2C_RD_ACK: begin
          if (s_q.rd) begin
            if (s_q.st == I2C_RD_ACK) s_d.sub = s_q.sub + 8'h01;
            s_d.sh = reg_read(s_q, s_d.sub);
            s_d.sda_oe = !s_d.sh[7];
            s_d.bit_cnt = 4'h1;
            s_d.st = I2C_RD;
          end else begin
            s_d.sda_oe = 1'b0;
            s_d.bit_cnt = 4'h0;
            s_d.st = I2C_SUB;
          end
        end
        I2C_SUB: begin
          if (s_q.bit_cnt == 4'h8) begin
            s_d.sub = s_q.sh;
            s_d.sda_oe = 1'b1;
            s_d.st = I2C_SUB_ACK;
          end
        end
        I2C_SUB_ACK, I2C_WR_ACK: begin
          if (s_q.st == I2C_WR_ACK) s_d.sub = s_q.sub + 8'h01;
          s_d.sda_oe = 1'b0;
          s_d.bit_cnt = 4'h0;
          s_d.st = I2C_WR;
        end
        I2C_WR: begin
          if (s_q.bit_cnt == 4'h8) begin
            s_d = reg_write(s_d, s_q.sub, s_q.sh);
            s_d.sda_oe = 1'b1;
            s_d.st = I2C_WR_ACK;
          end
        end
        I2C_RD: begin
          if (s_q.bit_cnt == 4'h8) begin
            s_d.sda_oe = 1'b0;
            s_d.st = I2C_RD_ACK;
          end else begin
            s_d.sh = {s_q.sh[6:0], 1'b0};
            s_d.sda_oe = !s_q.sh[6];
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end
        end
        default: s_d.st = I2C_IDLE;
      endcase
    end

    // ----------------------------------------
    // Activity detection
    // ----------------------------------------
    s_d.act_prev = act_in;
    for (int i = 0; i < 6; i++) begin
      if (act_in[i] != s_q.act_prev[i]) begin
        s_d.act_cnt[i] = CW'(ACT_TIMEOUT); // R23
        s_d.act[i] = 1'b1; // R17
      end else if (s_q.act_cnt[i] == '0) begin
        s_d.act[i] = 1'b0; // R23
      end else begin
        s_d.act_cnt[i] = s_q.act_cnt[i] - CW'(1);
      end
    end

    // ----------------------------------------
    // Sync selection, glitch filter, separator
    // ----------------------------------------
    hs_act = s_q.act[0] || s_q.act[1];
    hs_pin = s_q.act[0] ? hsync_in[0] : hsync_in[1];
    if (s_q.act[3]) sog_raw = green_embedded_sync_input[0];
    else if (s_q.act[4]) sog_raw = green_embedded_sync_input[1];
    else if (s_q.act[5]) sog_raw = green_embedded_sync_input[2];
    else sog_raw = green_embedded_sync_input[0];
    gf_limit = (3'h1 << s_q.glitch[1:0]) - 3'h1;
    if (s_q.glitch[1:0] == 2'h0 || sog_raw == s_q.gf_level) begin
      s_d.gf_level = sog_raw; // R15
      s_d.gf_cnt = 3'h0;
    end else if (s_q.gf_cnt >= gf_limit) begin
      s_d.gf_level = sog_raw; // R15
      s_d.gf_cnt = 3'h0;
    end else begin
      s_d.gf_cnt = s_q.gf_cnt + 3'h1;
    end
    if (s_q.sync_sel[`HSYNC_AUTO_OUTPUT_SELECT_BIT]) ref_d = hs_act ? hs_pin : s_q.gf_level; // R12 R21
    else ref_d = s_q.sync_sel[`HMAN_SOG_BIT] ? s_q.gf_level : hs_pin;
    s_d.ref_sync = ref_d;
    // Field rates below 33 Hz are outside what this separator handles
    s_d.cs_prev = s_q.ref_sync;
    if (s_q.ref_sync && !s_q.cs_prev) begin
      s_d.width = 9'h000;
      s_d.long_p = 1'b0;
    end else if (s_q.ref_sync) begin
      if (s_q.width != 9'(`VSEP_CYCLES)) begin
        s_d.width = s_q.width + 9'h001;
      end else begin
        s_d.long_p = 1'b1;
        s_d.vsep = 1'b1; // R16
      end
    end else if (s_q.cs_prev && !s_q.long_p) begin
      s_d.vsep = 1'b0; // R16
    end
    if (s_q.sync_sel[`VSYNC_AUTO_OUTPUT_SELECT_BIT]) begin
      s_d.vs_out = (hs_act && s_q.act[2]) ? vsync_in : s_q.vsep; // R19 R20 R21
    end else begin
      s_d.vs_out = s_q.sync_sel[`VMAN_SEP_BIT] ? s_q.vsep : vsync_in;
    end

    // ----------------------------------------
    // Colour conversion and chroma decimation
    // ----------------------------------------
    if (s_q.csc_ctrl[`CSC_BYPASS_BIT]) begin
      yc = pix_green; // R6
      cbc = pix_blue;
      crc = pix_red;
    end else begin
      yc = csc_mac(coef_word(s_q, 0), coef_word(s_q, 1), coef_word(s_q, 2),
          pix_green, pix_blue, pix_red, 10'h000); // R7
      cbc = csc_mac(coef_word(s_q, 3), coef_word(s_q, 4), coef_word(s_q, 5),
          pix_green, pix_blue, pix_red, `CHROMA_OFFSET);
      crc = csc_mac(coef_word(s_q, 6), coef_word(s_q, 7), coef_word(s_q, 8),
          pix_green, pix_blue, pix_red, `CHROMA_OFFSET);
    end
    if (s_q.fmt[`FORMAT_422_BIT]) begin
      red_d = 10'h000;
      blue_d = s_q.phase ? s_q.cr_hold : halfband(s_q.cb_line); // R10 R11
    end else begin
      red_d = s_q.cr_line[13];
      blue_d = s_q.cb_line[13];
    end
    if (push) begin
      s_d.y_line = {s_q.y_line[12:0], yc};
      s_d.cb_line = {s_q.cb_line[25:0], cbc}; // R11
      s_d.cr_line = {s_q.cr_line[25:0], crc};
      if (s_q.fmt[`FORMAT_422_BIT]) begin
        s_d.phase = !s_q.phase; // R10
        if (!s_q.phase) s_d.cr_hold = halfband(s_q.cr_line); // R8
      end else begin
        s_d.phase = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.st <= I2C_IDLE;
      s_q.scl_q <= 1'b1;
      s_q.sda_q <= 1'b1;
      s_q.slice <= `SLICE_RESET; // R14
      s_q.sync_sel <= `SYNC_SELECT_RESET;
      s_q.csc_ctrl <= `CSC_CTRL_RESET; // R6
      s_q.coef <= `COEF_RESET; // R7
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Output buffer and pins
  // ----------------------------------------
  two_entry_buffer #(
    .WIDTH(30)
  ) u_out_buffer (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_data({s_q.y_line[13], blue_d, red_d}),
    .in_valid(pix_valid),
    .in_ready(buf_ready),
    .out_data({green_output_bus, blue_output_bus, red_output_bus}),
    .out_valid(out_valid),
    .out_ready(out_ready)
  );

  assign pix_ready = buf_ready;
  assign sda_out = s_q.sda_out;
  assign sda_oe = s_q.sda_oe;
  assign pll_feedback_divide = {s_q.div_hi, s_q.div_lo[7:`DIV_LOW_LSB]}; // R2
  assign vco_range = s_q.vco_pump[`VCO_LSB+:2]; // R3
  assign charge_pump_setting = s_q.vco_pump[`PUMP_LSB+:3]; // R4
  assign pll_output_divide = s_q.out_div[0]; // R5
  assign sample_clock_external = s_q.clk_src[`EXT_CLK_BIT]; // R1
  assign slice_threshold_code = s_q.slice[`SLICE_LSB+:5]; // R14
  assign glitch_filter_cutoff = s_q.glitch[1:0];
  assign sliced_sync_output = s_q.gf_level; // R13
  assign pll_ref_sync = s_q.ref_sync; // R12
  assign hsync_out = s_q.ref_sync;
  assign vsync_out = s_q.vs_out;
endmodule // video_digitizer_back_end

// *** test/video_digitizer_back_end_asserts.sv ***
`timescale 1ns/100ps
module video_digitizer_back_end_asserts (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [1:0] hsync_in,
  input wire logic vsync_in,
  input wire logic [2:0] green_embedded_sync_input,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire digitizer_pkg::sample_t green_output_bus,
  input wire digitizer_pkg::sample_t blue_output_bus,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [4:0] slice_threshold_code,
  input wire logic [1:0] glitch_filter_cutoff,
  input wire logic sliced_sync_output,
  input wire logic pll_ref_sync,
  input wire logic hsync_out,
  input wire logic vsync_out
);
  import digitizer_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_reset_values: assert property ($fell(reset) |-> slice_threshold_code == 5'd11
    && !out_valid && pix_ready && !sda_oe) else $error("bad state after reset");
  a_sync_pair: assert property (hsync_out == pll_ref_sync)
    else $error("pll reference differs from hsync output");
  a_hsync_pin: assert property ($changed(hsync_in[0]) ##1 $stable(hsync_in[0])[*5]
    |-> pll_ref_sync == hsync_in[0]) else $error("pll reference not from active pin");
  a_vsync_pin: assert property ($changed(vsync_in) ##1 $stable(vsync_in)[*5]
    |-> vsync_out == vsync_in) else $error("vsync output not from active pin");
  a_slice_bypass: assert property ((glitch_filter_cutoff == 2'd0
    && $stable(green_embedded_sync_input) && (&green_embedded_sync_input
    || ~|green_embedded_sync_input))[*3] |-> sliced_sync_output == green_embedded_sync_input[0])
    else $error("sliced sync does not follow green sync");
  a_word_holds: assert property (out_valid && !out_ready |=> out_valid
    && $stable(green_output_bus) && $stable(blue_output_bus)) else $error("word changed");
  a_full_holds: assert property (!pix_ready && !out_ready |=> !pix_ready)
    else $error("ready rose while buffer could not drain");
  a_ack_timing: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
  a_sda_low: assert property (sda_out == 1'b0) else $error("data line driven high");
  c_pixel: cover property (pix_valid && pix_ready);
  c_full: cover property (!pix_ready && !out_ready);
  c_vsync: cover property ($rose(vsync_out));
endmodule // video_digitizer_back_end_asserts

bind video_digitizer_back_end video_digitizer_back_end_asserts u_video_digitizer_back_end_asserts (
  .clk_sys, .reset, .scl_in, .sda_out, .sda_oe, .hsync_in, .vsync_in,
  .green_embedded_sync_input, .pix_valid, .pix_ready, .green_output_bus, .blue_output_bus,
  .out_valid, .out_ready, .slice_threshold_code, .glitch_filter_cutoff, .sliced_sync_output,
  .pll_ref_sync, .hsync_out, .vsync_out
);

// *** test/video_source_model.sv ***
`timescale 1ns/100ps
module video_source_model (
  input wire logic clk_sys,
  input wire logic h_en,
  input wire logic v_en,
  input wire logic g_en,
  output logic [1:0] hsync_in,
  output logic vsync_in,
  output logic [2:0] green_embedded_sync_input
);
  logic [5:0] cnt_q;
  initial begin
    cnt_q = 6'h00;
    hsync_in = 2'h0;
    vsync_in = 1'b0;
    green_embedded_sync_input = 3'h0;
  end
  // Stopped syncs hold still, so the block must see no activity
  // Vertical edges are kept apart from horizontal ones
  always @(posedge clk_sys) begin
    cnt_q <= cnt_q + 6'h01;
    if (h_en && cnt_q[3:0] == 4'h0) hsync_in[0] <= ~hsync_in[0];
    if (v_en && cnt_q == 6'h25) vsync_in <= ~vsync_in;
    if (g_en && cnt_q[3:0] == 4'h8) green_embedded_sync_input <= ~green_embedded_sync_input;
  end
endmodule // video_source_model

// *** test/video_digitizer_back_end_tb.sv ***
`timescale 1ns/100ps
module video_digitizer_back_end_tb;
  import digitizer_pkg::*;
  localparam logic [6:0] DEV = 7'h5C;
  logic clk_sys, reset = 1'b1, scl_in = 1'b1, sda_m = 1'b1, sda_in, sda_out, sda_oe;
  logic h_en = 1'b0, v_en = 1'b0, g_en = 1'b0, vsync_in, pix_valid = 1'b0, pix_ready;
  logic out_valid, out_ready = 1'b1, pll_output_divide, sample_clock_external;
  logic sliced_sync_output, pll_ref_sync, hsync_out, vsync_out;
  logic [1:0] hsync_in, vco_range, glitch_filter_cutoff;
  logic [2:0] green_embedded_sync_input, charge_pump_setting;
  logic [4:0] slice_threshold_code;
  logic [11:0] pll_feedback_divide;
  logic [29:0] w0, w1;
  sample_t pix_green = 10'h000, pix_blue = 10'h000, pix_red = 10'h000;
  sample_t green_output_bus, blue_output_bus, red_output_bus;
  int n_errors = 0, tests_run = 0;
  assign sda_in = sda_m & ~sda_oe;
  video_source_model u_video_source_model (.clk_sys, .h_en, .v_en, .g_en, .hsync_in,
    .vsync_in, .green_embedded_sync_input);
  video_digitizer_back_end #(.DEVICE_ADDR(DEV), .ACT_TIMEOUT(100)) u_video_digitizer_back_end (
    .clk_sys, .reset, .scl_in, .sda_in, .sda_out, .sda_oe, .hsync_in, .vsync_in,
    .green_embedded_sync_input, .pix_green, .pix_blue, .pix_red, .pix_valid, .pix_ready,
    .green_output_bus, .blue_output_bus, .red_output_bus, .out_valid, .out_ready,
    .pll_feedback_divide, .vco_range, .charge_pump_setting, .pll_output_divide,
    .sample_clock_external, .slice_threshold_code, .glitch_filter_cutoff,
    .sliced_sync_output, .pll_ref_sync, .hsync_out, .vsync_out);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (out_valid && out_ready) begin
    w1 <= w0;
    w0 <= {green_output_bus, blue_output_bus, red_output_bus};
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [29:0] exp, input logic [29:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic i2c_bit(input logic b, output logic s);
    sda_m <= b;
    tick(4);
    scl_in <= 1'b1;
    tick(4);
    s = sda_in;
    scl_in <= 1'b0;
    tick(4);
  endtask
  task automatic i2c_start();
    sda_m <= 1'b1;
    tick(4);
    scl_in <= 1'b1;
    tick(4);
    sda_m <= 1'b0;
    tick(4);
    scl_in <= 1'b0;
    tick(4);
  endtask
  task automatic i2c_stop();
    sda_m <= 1'b0;
    tick(4);
    scl_in <= 1'b1;
    tick(4);
    sda_m <= 1'b1;
    tick(4);
  endtask
  task automatic i2c_byte(input logic [7:0] d, input logic ack_m, input logic wr,
                          output logic [7:0] q);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(d[i], s);
      q[i] = s;
    end
    i2c_bit(ack_m, s);
    if (wr) chk("ack", 30'h0, 30'(s));
  endtask
  task automatic reg_wr(input logic [7:0] sub, input logic [7:0] d[$]);
    logic [7:0] q;
    i2c_start();
    i2c_byte({DEV, 1'b0}, 1'b1, 1'b1, q);
    i2c_byte(sub, 1'b1, 1'b1, q);
    foreach (d[i]) i2c_byte(d[i], 1'b1, 1'b1, q);
    i2c_stop();
  endtask
  task automatic reg_rd(input logic [7:0] sub, input logic [7:0] e[$]);
    logic [7:0] q;
    i2c_start();
    i2c_byte({DEV, 1'b0}, 1'b1, 1'b1, q);
    i2c_byte(sub, 1'b1, 1'b1, q);
    i2c_start();
    i2c_byte({DEV, 1'b1}, 1'b1, 1'b1, q);
    foreach (e[i]) begin
      i2c_byte(8'hFF, 1'(i == e.size() - 1), 1'b0, q);
      chk($sformatf("reg %h", sub + 8'(i)), 30'(e[i]), 30'(q));
    end
    i2c_stop();
  endtask
  task automatic send(input sample_t g, input sample_t b, input sample_t r, input int n);
    int k;
    k = 0;
    pix_green <= g;
    pix_blue <= b;
    pix_red <= r;
    pix_valid <= 1'b1;
    for (int t = 0; t < 400 && k < n; t++) begin
      @(posedge clk_sys);
      if (pix_ready === 1'b1) k++;
    end
    pix_valid <= 1'b0;
    tick(4);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    tick(4);
    reset <= 1'b0;
    tick(2);
    chk("slice code", 30'd11, 30'(slice_threshold_code));
    chk("glitch cutoff", 30'h0, 30'(glitch_filter_cutoff));
    reg_rd(8'h10, '{8'h58});
    reg_rd(8'h0E, '{8'h90});
    reg_rd(8'h18, '{8'h10});
    reg_rd(8'h4A, '{8'h16, 8'hE3, 8'h02, 8'h4F});
    reg_rd(8'h52, '{8'h10, 8'h00});
    reg_rd(8'h7F, '{8'h00});
    $display("test reset_values done");
    reg_wr(8'h01, '{8'hAB, 8'hC5, 8'hD2, 8'h01});
    chk("divider", 30'h0ABC, 30'(pll_feedback_divide));
    chk("vco range", 30'h3, 30'(vco_range));
    chk("pump", 30'h2, 30'(charge_pump_setting));
    chk("out divide", 30'h1, 30'(pll_output_divide));
    reg_wr(8'h1F, '{8'h01});
    chk("ext clock", 30'h1, 30'(sample_clock_external));
    reg_wr(8'h10, '{8'hF8});
    chk("slice code", 30'd31, 30'(slice_threshold_code));
    reg_wr(8'h14, '{8'hFF});
    reg_rd(8'h14, '{8'h00});
    $display("test registers done");
    out_ready <= 1'b0;
    send(10'd100, 10'd200, 10'd300, 2);
    tick(2);
    chk("ready when full", 30'h0, 30'(pix_ready));
    chk("valid when full", 30'h1, 30'(out_valid));
    out_ready <= 1'b1;
    send(10'd100, 10'd200, 10'd300, 20);
    chk("bypass word", {10'd100, 10'd200, 10'd300}, w0);
    reg_wr(8'h18, '{8'h00});
    send(10'd0, 10'd1023, 10'd0, 20);
    chk("converted word", {10'd148, 10'd1023, 10'd418}, w0);
    reg_wr(8'h15, '{8'h02});
    send(10'd0, 10'd1023, 10'd0, 20);
    chk("luma 422", 30'd148, 30'(w0[29:20]));
    chk("red 422", 30'd0, 30'({w0[9:0], w1[9:0]}));
    chk("chroma pair", 30'd1441, 30'({1'b0, w0[19:10]} + {1'b0, w1[19:10]}));
    $display("test pixels done");
    h_en <= 1'b1;
    tick(20);
    v_en <= 1'b1;
    tick(100);
    reg_rd(8'h14, '{8'h03});
    @(hsync_in[0]);
    tick(5);
    chk("pll from pin", 30'(hsync_in[0]), 30'(pll_ref_sync));
    @(vsync_in);
    tick(5);
    chk("vsync from pin", 30'(vsync_in), 30'(vsync_out));
    h_en <= 1'b0;
    v_en <= 1'b0;
    g_en <= 1'b1;
    tick(300);
    reg_rd(8'h14, '{8'h04});
    @(green_embedded_sync_input[0]);
    tick(5);
    chk("hsync from green", 30'(green_embedded_sync_input[0]), 30'(hsync_out));
    chk("sliced sync", 30'(green_embedded_sync_input[0]), 30'(sliced_sync_output));
    $display("test sync done");
    print_verdict();
  end
  initial begin
    tick(40000);
    n_errors++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule // video_digitizer_back_end_tb
